// ### shared/csf_pkg.sv
// Package for the contactless status, FIFO and mode register bank.
// Assumes a single 250 MHz system clock shared with the host port and engines.
package csf_pkg;
   localparam int CSF_DEPTH = 64;
   localparam logic [6:0] CSF_DEPTH_W = 7'h40;
   localparam int CSF_ID_BYTES = 10;
   localparam logic [3:0] CSF_ID_LAST = 4'h9;

   // Register offsets
   localparam logic [7:0] ADDR_ERROR = 8'h06;
   localparam logic [7:0] ADDR_STATUS1 = 8'h07;
   localparam logic [7:0] ADDR_STATUS2 = 8'h08;
   localparam logic [7:0] ADDR_FIFO_DATA = 8'h09;
   localparam logic [7:0] ADDR_FIFO_LEVEL = 8'h0a;
   localparam logic [7:0] ADDR_WATER = 8'h0b;
   localparam logic [7:0] ADDR_CONTROL = 8'h0c;
   localparam logic [7:0] ADDR_COLL = 8'h0e;
   localparam logic [7:0] ADDR_MODE = 8'h11;

   // Reset values
   localparam logic [5:0] WATER_RST = 6'h08;
   localparam logic [7:0] MODE_RST = 8'h3b;
   localparam logic [7:0] COLL_READ = 8'ha0;

   // Field positions
   localparam int ERR_OVFL = 4;
   localparam int ERR_COLL = 3;
   localparam int ERR_CRC = 2;
   localparam int ERR_PAR = 1;
   localparam int ERR_PROT = 0;
   localparam int LVL_FLUSH = 7;
   localparam int CTL_STOP = 7;
   localparam int CTL_START = 6;
   localparam int CTL_COPY = 5;
   localparam int ST2_FORCE = 6;
   localparam int MODE_SYNC = 6;
   localparam int MODE_DETOFF = 2;

   // Receive speeds
   localparam logic [2:0] SPEED_106 = 3'h0;

   // Checksum presets
   localparam logic [15:0] PRESET_0000 = 16'h0000;
   localparam logic [15:0] PRESET_6363 = 16'h6363;
   localparam logic [15:0] PRESET_A671 = 16'ha671;
   localparam logic [15:0] PRESET_FFFF = 16'hffff;
   localparam logic [7:0] SYNC_BYTE = 8'hf0;

   // Carrier band in Hz
   localparam int FREQ_LO_HZ = 12000000;
   localparam int FREQ_HI_HZ = 15000000;

   typedef enum logic [2:0] {
      XS_IDLE = 3'b000,
      XS_WAIT_SEND = 3'b001,
      XS_TX_WAIT = 3'b010,
      XS_SENDING = 3'b011,
      XS_RX_WAIT = 3'b100,
      XS_WAIT_DATA = 3'b101,
      XS_RECEIVING = 3'b110
   } csf_xstate_t;
endpackage

// ### verilog/csf_mem.sv
`timescale 1ns/100ps
// Byte memory for the 64-entry buffer, registered read data.
// Assumes the caller never writes and reads the same entry expecting bypass.
module csf_mem
   import csf_pkg::*;
(
   input wire logic clk,
   input wire logic we,
   input wire logic [5:0] waddr,
   input wire logic [7:0] wdata,
   input wire logic [5:0] raddr,
   output logic [7:0] rdata
);
   logic [7:0] mem [0:CSF_DEPTH-1];

   // Storage has no reset; read data registered every cycle
   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule

// ### verilog/csf_sync.sv
`timescale 1ns/100ps
// Three-stage synchroniser for a level from outside the clock domain.
// Output changes only once stages two and three agree.
module csf_sync
   import csf_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic din,
   output logic dout
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic q;
   } csf_sync_t;
   csf_sync_t r, next_r;

   // Stage one feeds only stage two
   always_comb begin
      next_r = r;
      next_r.s1 = din;
      next_r.s2 = r.s1;
      next_r.s3 = r.s2;
      if (r.s2 == r.s3) begin
         next_r.q = r.s3;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign dout = r.q;
endmodule

// ### verilog/csf_regs.sv
// The plain strobed port was decided locally.
`timescale 1ns/100ps
// Status, error, buffer and mode register bank of a contactless frontend.
// Assumes the host port and the receive, checksum and timer engines share clk.
// Notes on behaviour
// - Any write into a full buffer sets the overflow error flag.
// - Collision flag set on collision, cleared at receiver start, reads 1 above 106k.
// - Checksum fail flag set on bad receive checksum when enabled, cleared at start.
// - Parity fail flag set on parity error, cleared at receiver start.
// - Framing flag on bad start, initiator in anticollision, or close decoder pulses.
// - Carrier valid shows frequency strictly between 12 and 15 MHz.
// - Standalone checksum: zero status low while running, done flag at finish.
// - Combined interrupt status is any enabled request flag.
// - Timer active follows register start and stop, not the gate.
// - Field present bit is live, never latched.
// - Nearly full when 64 minus count is at most the threshold.
// - Nearly empty when count is at most the threshold.
// - Three-bit transceiver state is shown with fixed encodings.
// - Force fast filter bit selects high speed host bus filter.
// - Byte data port into 64-byte buffer; writes count up, reads down.
// - Clear strobe resets pointers and reads zero; clears overflow unless a full write lands that cycle.
// - Halt and go strobes stop or start timer and read zero.
// - Copy strobe loads ten identifier bytes into buffer then self-clears.
// - Last byte valid bits field is read only; zero means whole byte.
// - Sync enable waits for F0 before receiving and prepends F0 on send.
// - Error interrupt request set whenever any error flag is set.
// - Alert conditions latch into request flags until software clears.
module csf_regs
   import csf_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic eng_push,
   input wire logic [7:0] eng_push_data,
   output logic eng_push_ready,
   input wire logic eng_pop,
   output logic [7:0] eng_pop_data,
   input wire logic rx_start,
   input wire logic rx_collision,
   input wire logic rx_checksum_bad,
   input wire logic receive_checksum_enable,
   input wire logic [2:0] rx_speed,
   input wire logic rx_parity_bad,
   input wire logic rx_bad_sof,
   input wire logic autocoll_active,
   input wire logic initiator,
   input wire logic miller_short_pulse,
   input wire logic [31:0] carrier_freq_hz,
   input wire logic calc_start,
   input wire logic calc_done,
   input wire logic calc_result_zero,
   input wire logic [6:0] irq_enable,
   input wire logic [4:0] irq_other,
   input wire logic [1:0] irq_clear,
   output logic irq_status,
   output logic nearly_full_interrupt_request,
   output logic nearly_empty_interrupt_request,
   output logic error_interrupt_request,
   output logic timer_active_status,
   input wire logic timer_expired,
   input wire logic field_detect_pin,
   input wire logic [2:0] transceiver_state,
   output logic force_fast_filter,
   input wire logic [2:0] last_byte_valid_bits,
   output logic sync_byte_enable,
   output logic mode_detector_run,
   input wire logic [79:0] card_identifier,
   input wire logic [15:0] rf_preset,
   output logic [15:0] checksum_preset
);
   typedef struct packed {
      logic [5:0] wp;
      logic [5:0] rp;
      logic [6:0] cnt;
      logic ovfl;
      logic coll;
      logic crc_err;
      logic par;
      logic prot;
      logic crc_ok;
      logic crc_ready;
      logic calc_busy;
      logic timer_run;
      logic [5:0] water;
      logic force_fast;
      logic [7:0] mode;
      logic copying;
      logic [3:0] copy_idx;
      logic hi_irq;
      logic lo_irq;
      logic err_irq;
      logic rd_fifo_q;
      logic [7:0] rd_reg;
      logic [7:0] pop_data;
   } csf_regs_t;
   csf_regs_t r, next_r;

   logic field_on;
   logic [7:0] mem_rdata;
   logic push_host;
   logic push_any;
   logic [7:0] push_data;
   logic pop_any;
   logic [5:0] pop_addr;
   logic nearly_full;
   logic nearly_empty;
   logic freq_ok;
   logic flush;
   logic [7:0] err_byte;
   logic [7:0] st1_byte;

   csf_sync u_field (
      .clk(clk),
      .rst_n(rst_n),
      .din(field_detect_pin),
      .dout(field_on)
   );

   csf_mem u_mem (
      .clk(clk),
      .we(push_any && (r.cnt != CSF_DEPTH_W)),
      .waddr(r.wp),
      .wdata(push_data),
      .raddr(pop_addr),
      .rdata(mem_rdata)
   );

   // Buffer access sources; identifier copy has priority over engine pushes
   always_comb begin
      push_host = wr && (addr == ADDR_FIFO_DATA);
      flush = wr && (addr == ADDR_FIFO_LEVEL) && wdata[LVL_FLUSH];
      push_any = r.copying || push_host || eng_push;
      push_data = r.copying ? card_identifier[{r.copy_idx, 3'h0} +: 8]
                : (push_host ? wdata : eng_push_data);
      pop_any = ((rd && (addr == ADDR_FIFO_DATA)) || eng_pop) && (r.cnt != 7'h00);
      pop_addr = r.rp;
   end

   assign eng_push_ready = !r.copying && !push_host;

   // Thresholds
   always_comb begin
      nearly_full = ((CSF_DEPTH_W - r.cnt) <= {1'b0, r.water});
      nearly_empty = (r.cnt <= {1'b0, r.water});
      freq_ok = (carrier_freq_hz > FREQ_LO_HZ) && (carrier_freq_hz < FREQ_HI_HZ);
   end

   // Read views; collision reads one above base speed
   always_comb begin
      err_byte = '0;
      err_byte[ERR_OVFL] = r.ovfl;
      err_byte[ERR_COLL] = r.coll || (rx_speed != SPEED_106);
      err_byte[ERR_CRC] = r.crc_err;
      err_byte[ERR_PAR] = r.par;
      err_byte[ERR_PROT] = r.prot;
      st1_byte = {freq_ok, r.crc_ok, r.crc_ready, irq_status, r.timer_run,
                  field_on, nearly_full, nearly_empty};
   end

   // Next-state logic of the whole bank
   always_comb begin
      next_r = r;
      // Buffer pointers; a full write is dropped and flags overflow
      if (push_any && (r.cnt == CSF_DEPTH_W)) begin
         next_r.ovfl = 1'b1;
      end else if (flush) begin
         next_r.ovfl = 1'b0;
      end
      if (push_any && (r.cnt != CSF_DEPTH_W)) begin
         next_r.wp = r.wp + 6'h01;
      end
      if (pop_any) begin
         next_r.rp = r.rp + 6'h01;
      end
      case ({push_any && (r.cnt != CSF_DEPTH_W), pop_any})
         2'b10: next_r.cnt = r.cnt + 7'h01;
         2'b01: next_r.cnt = r.cnt - 7'h01;
         default: next_r.cnt = r.cnt;
      endcase
      if (flush) begin
         next_r.wp = '0;
         next_r.rp = '0;
         next_r.cnt = '0;
         next_r.copying = 1'b0;
      end
      // Receive errors: start-up clears, events set and win
      if (rx_start) begin
         next_r.coll = 1'b0;
         next_r.crc_err = 1'b0;
         next_r.par = 1'b0;
         next_r.prot = 1'b0;
      end
      if (rx_collision) begin
         next_r.coll = 1'b1;
      end
      if (rx_checksum_bad && receive_checksum_enable) begin
         next_r.crc_err = 1'b1;
      end
      if (rx_parity_bad) begin
         next_r.par = 1'b1;
      end
      if (rx_bad_sof || (autocoll_active && initiator) || miller_short_pulse) begin
         next_r.prot = 1'b1;
      end
      // Standalone checksum status
      if (calc_start) begin
         next_r.calc_busy = 1'b1;
         next_r.crc_ok = 1'b0;
         next_r.crc_ready = 1'b0;
      end else if (calc_done && r.calc_busy) begin
         next_r.calc_busy = 1'b0;
         next_r.crc_ok = calc_result_zero;
         next_r.crc_ready = 1'b1;
      end
      // Timer strobes; halt wins when both written; expiry stops the count
      if (wr && (addr == ADDR_CONTROL) && wdata[CTL_STOP]) begin
         next_r.timer_run = 1'b0;
      end else if (wr && (addr == ADDR_CONTROL) && wdata[CTL_START]) begin
         next_r.timer_run = 1'b1;
      end else if (timer_expired) begin
         next_r.timer_run = 1'b0;
      end
      // Identifier copy walks ten bytes, one per cycle
      if (wr && (addr == ADDR_CONTROL) && wdata[CTL_COPY] && !r.copying) begin
         next_r.copying = 1'b1;
         next_r.copy_idx = '0;
      end else if (r.copying) begin
         next_r.copy_idx = r.copy_idx + 4'h1;
         if (r.copy_idx == CSF_ID_LAST) begin
            next_r.copying = 1'b0;
         end
      end
      // Plain control writes
      if (wr && (addr == ADDR_WATER)) begin
         next_r.water = wdata[5:0];
      end
      if (wr && (addr == ADDR_STATUS2)) begin
         next_r.force_fast = wdata[ST2_FORCE];
      end
      if (wr && (addr == ADDR_MODE)) begin
         next_r.mode = wdata;
      end
      // Latched requests: a clear in the same cycle as the event loses
      if (irq_clear[1]) begin
         next_r.hi_irq = 1'b0;
      end
      if (irq_clear[0]) begin
         next_r.lo_irq = 1'b0;
      end
      if (nearly_full) begin
         next_r.hi_irq = 1'b1;
      end
      if (nearly_empty) begin
         next_r.lo_irq = 1'b1;
      end
      next_r.err_irq = |err_byte;
      // Register read data, one cycle after the strobe
      next_r.rd_fifo_q = rd && (addr == ADDR_FIFO_DATA) && (r.cnt != 7'h00);
      next_r.rd_reg = '0;
      if (rd) begin
         unique case (addr)
            ADDR_ERROR: next_r.rd_reg = err_byte;
            ADDR_STATUS1: next_r.rd_reg = st1_byte;
            ADDR_STATUS2: next_r.rd_reg = {1'b0, r.force_fast, 3'h0, transceiver_state};
            ADDR_FIFO_LEVEL: next_r.rd_reg = {1'b0, r.cnt};
            ADDR_WATER: next_r.rd_reg = {2'h0, r.water};
            ADDR_CONTROL: next_r.rd_reg = {2'h0, r.copying, 2'h0, last_byte_valid_bits};
            ADDR_COLL: next_r.rd_reg = COLL_READ;
            ADDR_MODE: next_r.rd_reg = r.mode;
            default: next_r.rd_reg = '0;
         endcase
      end
      next_r.pop_data = r.pop_data;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
         r.water <= WATER_RST;
         r.mode <= MODE_RST;
      end else begin
         r <= next_r;
      end
   end

   // Read data: buffer byte comes straight from the memory's register
   assign rdata = r.rd_fifo_q ? mem_rdata : r.rd_reg;
   assign eng_pop_data = mem_rdata;

   // Combined interrupt over latched and external request flags
   always_comb begin
      irq_status = |(irq_enable & {irq_other[4:2], r.hi_irq, r.lo_irq, r.err_irq,
                                   irq_other[0]});
   end

   assign nearly_full_interrupt_request = r.hi_irq;
   assign nearly_empty_interrupt_request = r.lo_irq;
   assign error_interrupt_request = r.err_irq;
   assign timer_active_status = r.timer_run;
   assign force_fast_filter = r.force_fast;
   assign sync_byte_enable = r.mode[MODE_SYNC];
   assign mode_detector_run = autocoll_active && !r.mode[MODE_DETOFF];

   // Preset table for the standalone command, engine choice during RF traffic
   always_comb begin
      if (r.calc_busy) begin
         unique case (r.mode[1:0])
            2'b00: checksum_preset = PRESET_0000;
            2'b01: checksum_preset = PRESET_6363;
            2'b10: checksum_preset = PRESET_A671;
            2'b11: checksum_preset = PRESET_FFFF;
         endcase
      end else begin
         checksum_preset = rf_preset;
      end
   end
endmodule

// ### sim/csf_regs_asserts.sv
`timescale 1ns/100ps
// Port checker for the csf register bank.
// Assumes one clock and an async active-low reset; bound below.
module csf_regs_asserts
   import csf_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata,
   input wire logic eng_push_ready,
   input wire logic rx_start,
   input wire logic rx_collision,
   input wire logic autocoll_active,
   input wire logic [6:0] irq_enable,
   input wire logic [4:0] irq_other,
   input wire logic [1:0] irq_clear,
   input wire logic irq_status,
   input wire logic nearly_full_interrupt_request,
   input wire logic nearly_empty_interrupt_request,
   input wire logic error_interrupt_request,
   input wire logic timer_active_status,
   input wire logic timer_expired,
   input wire logic field_detect_pin,
   input wire logic [2:0] transceiver_state,
   input wire logic [2:0] last_byte_valid_bits,
   input wire logic mode_detector_run
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Enabled request flags in the enable order
   a_irq_combined: assert property (irq_status == |(irq_enable & {irq_other[4:2],
      nearly_full_interrupt_request, nearly_empty_interrupt_request,
      error_interrupt_request, irq_other[0]})) else $error("combined irq wrong");
   a_flush_reads_zero: assert property (rd && addr == ADDR_FIFO_LEVEL |=> !rdata[7])
      else $error("clear strobe read back 1");
   a_strobes_zero: assert property (rd && addr == ADDR_CONTROL |=> rdata[7:6] == 2'h0)
      else $error("timer strobes read back 1");
   a_last_bits: assert property (rd && addr == ADDR_CONTROL |=>
      rdata[2:0] == $past(last_byte_valid_bits)) else $error("valid bits field wrong");
   a_state_shown: assert property (rd && addr == ADDR_STATUS2 |=>
      rdata[2:0] == $past(transceiver_state)) else $error("state field wrong");
   a_timer_go: assert property (wr && addr == ADDR_CONTROL && wdata[6] && !wdata[7]
      && !timer_expired |=> timer_active_status) else $error("timer did not start");
   a_timer_halt: assert property (wr && addr == ADDR_CONTROL && wdata[7]
      |=> !timer_active_status) else $error("timer did not stop");
   a_field_fall: assert property ((!field_detect_pin)[*6] ##0
      (rd && addr == ADDR_STATUS1) |=> !rdata[2]) else $error("field bit held");
   a_detector_gated: assert property (!autocoll_active |-> !mode_detector_run)
      else $error("detector ran outside anticollision");
   a_err_request: assert property (rx_collision && !rx_start |-> ##[1:2]
      error_interrupt_request) else $error("error request missing");
   a_empty_latched: assert property (nearly_empty_interrupt_request && !irq_clear[0]
      |=> nearly_empty_interrupt_request) else $error("low request dropped");
   a_copy_slot: assert property (wr && addr == ADDR_CONTROL && wdata[5]
      |=> (!eng_push_ready)[*8]) else $error("engine slot free during copy");
   // Main scenarios reached
   c_copy: cover property (wr && addr == ADDR_CONTROL && wdata[5]);
   c_coll: cover property (rx_collision);
   c_clear: cover property (nearly_empty_interrupt_request ##1 irq_clear[0]);
endmodule

bind csf_regs csf_regs_asserts csf_regs_asserts_i (.clk(clk), .rst_n(rst_n), .addr(addr),
   .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .eng_push_ready(eng_push_ready),
   .rx_start(rx_start), .rx_collision(rx_collision), .autocoll_active(autocoll_active),
   .irq_enable(irq_enable), .irq_other(irq_other), .irq_clear(irq_clear),
   .irq_status(irq_status), .nearly_full_interrupt_request(nearly_full_interrupt_request),
   .nearly_empty_interrupt_request(nearly_empty_interrupt_request),
   .error_interrupt_request(error_interrupt_request),
   .timer_active_status(timer_active_status), .timer_expired(timer_expired),
   .field_detect_pin(field_detect_pin), .transceiver_state(transceiver_state),
   .last_byte_valid_bits(last_byte_valid_bits), .mode_detector_run(mode_detector_run));

// ### sim/csf_host.sv
`timescale 1ns/100ps
// Host controller model on the register port.
// Assumes the bank never stalls and answers a read in the next cycle only.
module csf_host (
   output logic [7:0] addr,
   output logic [7:0] wdata,
   output logic wr,
   output logic rd,
   input wire logic clk,
   input wire logic [7:0] rdata
);
   // Idle bus from time zero
   initial begin
      addr = 8'h00;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
   end
   // One-cycle write, returns once the write has landed
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(negedge clk);
   endtask
   // Read data only stands one cycle, so take it then
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask
endmodule

// ### sim/csf_regs_tb.sv
`timescale 1ns/100ps
// Self-checking bench for the csf register bank.
// Assumes csf_pkg, csf_host and the bound checker are compiled first.
module csf_regs_tb
   import csf_pkg::*;
;
   logic clk, rst_n, wr, rd, eng_push, eng_pop, receive_checksum_enable;
   logic autocoll_active, initiator, calc_result_zero, timer_expired, field_detect_pin;
   logic eng_push_ready, irq_status, nearly_full_interrupt_request;
   logic nearly_empty_interrupt_request, error_interrupt_request, timer_active_status;
   logic force_fast_filter, sync_byte_enable, mode_detector_run;
   logic [7:0] addr, wdata, rdata, v, eng_push_data, eng_pop_data, ev;
   logic [2:0] rx_speed, transceiver_state, last_byte_valid_bits;
   logic [31:0] carrier_freq_hz;
   logic [6:0] irq_enable;
   logic [4:0] irq_other;
   logic [1:0] irq_clear;
   logic [79:0] card_identifier;
   logic [15:0] rf_preset, checksum_preset;
   int err_count, total_checks;

   csf_host csf_host_i (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata));
   // Event pulses share one vector: start, coll, crc, parity, sof, miller, calc
   csf_regs csf_regs_i (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .eng_push(eng_push), .eng_push_data(eng_push_data),
      .eng_push_ready(eng_push_ready), .eng_pop(eng_pop), .eng_pop_data(eng_pop_data),
      .rx_start(ev[0]), .rx_collision(ev[1]), .rx_checksum_bad(ev[2]),
      .receive_checksum_enable(receive_checksum_enable), .rx_speed(rx_speed),
      .rx_parity_bad(ev[3]), .rx_bad_sof(ev[4]), .autocoll_active(autocoll_active),
      .initiator(initiator), .miller_short_pulse(ev[5]), .carrier_freq_hz(carrier_freq_hz),
      .calc_start(ev[6]), .calc_done(ev[7]), .calc_result_zero(calc_result_zero),
      .irq_enable(irq_enable), .irq_other(irq_other), .irq_clear(irq_clear),
      .irq_status(irq_status), .nearly_full_interrupt_request(nearly_full_interrupt_request),
      .nearly_empty_interrupt_request(nearly_empty_interrupt_request),
      .error_interrupt_request(error_interrupt_request),
      .timer_active_status(timer_active_status), .timer_expired(timer_expired),
      .field_detect_pin(field_detect_pin), .transceiver_state(transceiver_state),
      .force_fast_filter(force_fast_filter), .last_byte_valid_bits(last_byte_valid_bits),
      .sync_byte_enable(sync_byte_enable), .mode_detector_run(mode_detector_run),
      .card_identifier(card_identifier), .rf_preset(rf_preset),
      .checksum_preset(checksum_preset));

   // 250 MHz clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // Read a register and compare the masked field
   task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      csf_host_i.rd_reg(a, v);
      chk(v & m, e);
   endtask
   task automatic fill(input int n);
      for (int i = 0; i < n; i++) csf_host_i.wr_reg(ADDR_FIFO_DATA, 8'(i));
   endtask
   task automatic pulse(input int k);
      @(posedge clk);
      ev <= 8'h01 << k;
      @(posedge clk);
      ev <= 8'h00;
      @(negedge clk);
   endtask
   task automatic t_fifo();
      rc(ADDR_WATER, 8'hff, 8'h08);
      rc(ADDR_MODE, 8'hff, 8'h3b);
      rc(8'h3f, 8'hff, 8'h00);
      fill(64);
      rc(ADDR_STATUS1, 8'h03, 8'h02);
      csf_host_i.wr_reg(ADDR_FIFO_DATA, 8'haa);
      rc(ADDR_FIFO_LEVEL, 8'hff, 8'h40);
      rc(ADDR_ERROR, 8'h10, 8'h10);
      chk({7'h00, error_interrupt_request}, 8'h01);
      rc(ADDR_FIFO_DATA, 8'hff, 8'h00);
      rc(ADDR_FIFO_DATA, 8'hff, 8'h01);
      rc(ADDR_FIFO_LEVEL, 8'hff, 8'h3e);
      csf_host_i.wr_reg(ADDR_FIFO_LEVEL, 8'h80);
      rc(ADDR_FIFO_LEVEL, 8'hff, 8'h00);
      rc(ADDR_ERROR, 8'h10, 8'h00);
      fill(64);
      // A full buffer refuses the engine as well as the host
      @(posedge clk);
      eng_push <= 1'b1;
      eng_push_data <= 8'h55;
      @(posedge clk);
      eng_push <= 1'b0;
      rc(ADDR_ERROR, 8'h10, 8'h10);
      rc(ADDR_FIFO_LEVEL, 8'hff, 8'h40);
      chk(eng_pop_data, 8'h00);
      @(posedge clk);
      eng_pop <= 1'b1;
      @(posedge clk);
      eng_pop <= 1'b0;
      rc(ADDR_FIFO_DATA, 8'hff, 8'h01);
      csf_host_i.wr_reg(ADDR_FIFO_LEVEL, 8'h80);
   endtask
   task automatic t_alerts();
      irq_enable <= 7'h04;
      csf_host_i.wr_reg(ADDR_WATER, 8'h04);
      fill(4);
      rc(ADDR_STATUS1, 8'h03, 8'h01);
      fill(1);
      rc(ADDR_STATUS1, 8'h03, 8'h00);
      chk({7'h00, nearly_empty_interrupt_request}, 8'h01);
      chk({7'h00, irq_status}, 8'h01);
      @(posedge clk);
      irq_clear <= 2'h1;
      @(posedge clk);
      irq_clear <= 2'h0;
      @(negedge clk);
      chk({7'h00, nearly_empty_interrupt_request}, 8'h00);
      chk({7'h00, irq_status}, 8'h00);
      fill(55);
      rc(ADDR_STATUS1, 8'h03, 8'h02);
      csf_host_i.rd_reg(ADDR_FIFO_DATA, v);
      rc(ADDR_STATUS1, 8'h03, 8'h00);
      chk({7'h00, nearly_full_interrupt_request}, 8'h01);
   endtask
   task automatic t_errors();
      for (int k = 1; k < 6; k++) begin
         pulse(k);
         rc(ADDR_ERROR, 8'h0f, (k < 5) ? 8'h10 >> k : 8'h01);
         pulse(0);
         if (k < 5) rc(ADDR_ERROR, 8'h0f, 8'h00);
      end
      receive_checksum_enable <= 1'b0;
      pulse(2);
      rc(ADDR_ERROR, 8'h04, 8'h00);
      autocoll_active <= 1'b1;
      initiator <= 1'b1;
      rc(ADDR_ERROR, 8'h01, 8'h01);
      initiator <= 1'b0;
      rx_speed <= 3'h1;
      rc(ADDR_ERROR, 8'h08, 8'h08);
      rx_speed <= 3'h0;
   endtask
   task automatic t_ctrl();
      csf_host_i.wr_reg(ADDR_CONTROL, 8'h40);
      chk({7'h00, timer_active_status}, 8'h01);
      rc(ADDR_STATUS1, 8'h08, 8'h08);
      csf_host_i.wr_reg(ADDR_CONTROL, 8'hc0);
      rc(ADDR_STATUS1, 8'h08, 8'h00);
      csf_host_i.wr_reg(ADDR_FIFO_LEVEL, 8'h80);
      csf_host_i.wr_reg(ADDR_CONTROL, 8'h20);
      chk({7'h00, eng_push_ready}, 8'h00);
      rc(ADDR_CONTROL, 8'h20, 8'h20);
      repeat (12) @(posedge clk);
      rc(ADDR_CONTROL, 8'h20, 8'h00);
      rc(ADDR_FIFO_LEVEL, 8'hff, 8'h0a);
      for (int j = 0; j < 10; j++) rc(ADDR_FIFO_DATA, 8'hff, card_identifier[8*j +: 8]);
      for (int s = 0; s < 7; s++) begin
         @(posedge clk);
         transceiver_state <= 3'(s);
         rc(ADDR_STATUS2, 8'h07, 8'(s));
      end
      csf_host_i.wr_reg(ADDR_STATUS2, 8'h40);
      chk({7'h00, force_fast_filter}, 8'h01);
      csf_host_i.wr_reg(ADDR_MODE, 8'h7f);
      chk({mode_detector_run, 6'h00, sync_byte_enable}, 8'h01);
      // Preset select 01 for the standalone checksum below
      csf_host_i.wr_reg(ADDR_MODE, 8'h39);
      chk({mode_detector_run, 6'h00, sync_byte_enable}, 8'h80);
      calc_result_zero <= 1'b1;
      pulse(6);
      chk(checksum_preset[15:8], 8'h63);
      chk(checksum_preset[7:0], 8'h63);
      pulse(7);
      rc(ADDR_STATUS1, 8'h60, 8'h60);
      chk(checksum_preset[7:0], 8'h34);
      // A new start must pull both bits down from one
      pulse(6);
      rc(ADDR_STATUS1, 8'h60, 8'h00);
      field_detect_pin <= 1'b1;
      // Pin passes three flops before the bit follows
      repeat (6) @(posedge clk);
      rc(ADDR_STATUS1, 8'h04, 8'h04);
      field_detect_pin <= 1'b0;
      repeat (6) @(posedge clk);
      rc(ADDR_STATUS1, 8'h04, 8'h00);
      carrier_freq_hz <= 32'(FREQ_LO_HZ + 1);
      rc(ADDR_STATUS1, 8'h80, 8'h80);
      carrier_freq_hz <= 32'(FREQ_HI_HZ);
      rc(ADDR_STATUS1, 8'h80, 8'h00);
      last_byte_valid_bits <= 3'h5;
      rc(ADDR_CONTROL, 8'h07, 8'h05);
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Cut a hang short; the whole run needs under 5000 cycles
   initial begin
      repeat (40000) @(posedge clk);
      err_count++;
      end_of_test();
   end
   // Quiet inputs, reset for 8 cycles, then the scenarios
   initial begin
      {rst_n, eng_push, eng_pop, autocoll_active, initiator, calc_result_zero} = '0;
      {timer_expired, field_detect_pin, ev, eng_push_data, rx_speed} = '0;
      {transceiver_state, last_byte_valid_bits, irq_enable, irq_other, irq_clear} = '0;
      {carrier_freq_hz, rf_preset} = {32'h0, 16'h1234};
      receive_checksum_enable = 1'b1;
      card_identifier = 80'h99887766554433221100;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      t_fifo();
      t_alerts();
      t_errors();
      t_ctrl();
      end_of_test();
   end
endmodule
